// *** exc_entry_pkg.sv ***
// constants for the exception-entry unit
package exc_entry_pkg;
  // vector offsets
  localparam logic [31:0] VEC_PROGRAM = 32'h0000_0700;
  localparam logic [31:0] VEC_FP_UNAVAIL = 32'h0000_0800;
  localparam logic [31:0] VEC_DECREMENTER = 32'h0000_0900;
  localparam logic [31:0] VEC_SYSCALL = 32'h0000_0C00;
  localparam logic [31:0] VEC_BASE_LOW = 32'h0000_0000;
  localparam logic [31:0] VEC_BASE_HIGH = 32'hFFF0_0000;
  // APB register byte offsets
  localparam logic [7:0] ADDR_MSTATE = 8'h00;
  localparam logic [7:0] ADDR_SR_ADDR = 8'h04;
  localparam logic [7:0] ADDR_SR_STAT = 8'h08;
  localparam logic [7:0] ADDR_SYNDROME = 8'h0C;
  localparam logic [7:0] ADDR_DECR = 8'h10;
  localparam logic [7:0] ADDR_FSTATUS = 8'h14;
  localparam logic [7:0] ADDR_EVENT = 8'h18;
  // machine-state bit positions (lsb numbering: pos = 31 - big-endian bit)
  localparam int MS_USER = 14;   // user_level_bit
  localparam int MS_FAVAIL = 13; // float_available
  localparam int MS_MCE = 12;    // machine_check_enable
  localparam int MS_FEA = 11;    // float_exc_mode_a
  localparam int MS_FEB = 8;     // float_exc_mode_b
  localparam int MS_IRQEN = 15;  // async_irq_enable
  localparam int MS_XBO = 16;    // exception_byte_order
  localparam int MS_VBASE = 6;   // vector_base_select
  localparam int MS_BO = 0;      // byte_order_bit
  localparam int FS_SUMMARY = 30; // float_enabled_summary
  // save-status cause bits
  localparam int SS_FPEN = 20;
  localparam int SS_PRIV = 18;
  localparam int SS_TRAP = 17;
  localparam int SS_LATER = 16;
  // syndrome class field (big-endian 15:21 = lsb 16:10)
  localparam int SYN_LSB = 10;
  localparam logic [6:0] CLS_LOAD_WORD = 7'h00;
  localparam logic [6:0] CLS_STORE_WORD = 7'h02;
  localparam logic [6:0] CLS_LOAD_WORD_IDX = 7'h60;
  localparam logic [1:0] LS_LOAD_WORD = 2'h0;
  localparam logic [1:0] LS_STORE_WORD = 2'h1;
  localparam logic [1:0] LS_LOAD_WORD_IDX = 2'h2;
  localparam logic [1:0] LS_RESERVED = 2'h3;
  localparam logic [31:0] DECR_RESET = 32'hFFFF_FFFF;
  localparam logic [31:0] APB_DEAD = 32'h0000_0000;
  typedef enum logic [2:0] {
    EV_NONE, EV_ALIGN, EV_PROGRAM, EV_FP_UNAVAIL, EV_DECR, EV_SYSCALL
  } event_type;
  typedef enum {ST_RUN, ST_SYNC} sync_state_type;
endpackage

// *** exception_entry_unit.sv ***
// exception-entry logic: detection, priority, save registers, decrementer
`timescale 1ns/100ps
module exception_entry_unit
  import exc_entry_pkg::*;
#(
  parameter int DECR_WIDTH = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // pipeline side, all same clock
  input wire logic i_valid,
  input wire logic [31:0] i_inst_addr,
  input wire logic [31:0] i_next_addr,
  input wire logic i_later_addr,
  input wire logic i_align_fault,
  input wire logic [1:0] i_ls_class,
  input wire logic i_is_state_read,
  input wire logic i_is_state_write,
  input wire logic i_is_return,
  input wire logic i_is_fstatus_write,
  input wire logic i_is_spr_move,
  input wire logic i_supervisor_reg_flag,
  input wire logic i_spr_valid_internal,
  input wire logic i_spr_external,
  input wire logic i_trap_met,
  input wire logic i_is_float,
  input wire logic i_float_arith_enabled,
  input wire logic i_unimplemented,
  input wire logic i_system_call_op,
  input wire logic i_inflight_empty,
  input wire logic [31:0] i_fstatus_wdata,
  input wire logic [31:0] i_state_wdata,
  input wire logic [31:0] i_return_state,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // redirect to fetch
  output logic o_redirect,
  output logic [31:0] o_redirect_addr,
  output logic o_halt_dispatch,
  output logic o_fp_assist,
  output logic o_sw_emulation,
  output logic [31:0] o_machine_state
);
  logic [31:0] machine_state_reg;
  logic [31:0] save_restore_address;
  logic [31:0] save_restore_status;
  logic [31:0] alignment_syndrome;
  logic [31:0] float_status_control;
  logic [DECR_WIDTH-1:0] decr;
  logic decr_pending;
  logic [31:0] event_count;
  sync_state_type sync_state;
  sync_state_type next_sync_state;
  event_type take;
  logic apb_wr;
  logic apb_rd;
  logic enabled_cond;
  logic fp_enabled_exc;
  logic priv_exc;
  logic trap_exc;
  logic program_exc;
  logic fp_unavail_exc;
  logic decr_exc;
  logic syscall_exc;
  logic syscall_go;
  logic [31:0] vec_base;
  logic [31:0] entry_state;
  logic [DECR_WIDTH-1:0] next_decr;
  logic decr_rise;
  logic sw_state_write;

  assign apb_wr = i_psel && i_penable && i_pwrite;
  assign apb_rd = i_psel && i_penable && !i_pwrite;
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;

  // enabled condition checked against the state that results from the op
  always_comb begin
    logic [31:0] ms;
    logic [31:0] fs;
    ms = machine_state_reg;
    fs = float_status_control;
    if (i_is_state_write) begin
      ms = i_state_wdata;
    end else if (i_is_return) begin
      ms = i_return_state;
    end
    if (i_is_fstatus_write) begin
      fs = i_fstatus_wdata;
    end
    enabled_cond = (ms[MS_FEA] | ms[MS_FEB]) & fs[FS_SUMMARY];
  end

  assign fp_enabled_exc = i_valid && enabled_cond &&
    (i_is_fstatus_write || i_is_state_write || i_is_return);
  // arithmetic producing the condition goes to the assist path
  assign o_fp_assist = i_valid && i_float_arith_enabled &&
    !i_unimplemented;
  assign o_sw_emulation = i_valid && i_unimplemented;
  assign priv_exc = i_valid && !i_unimplemented &&
    machine_state_reg[MS_USER] &&
    ((i_is_state_read || i_is_state_write || i_is_return) ||
     (i_is_spr_move && i_supervisor_reg_flag &&
      (i_spr_valid_internal || i_spr_external)));
  assign trap_exc = i_valid && !i_unimplemented && i_trap_met;
  assign program_exc = fp_enabled_exc || priv_exc || trap_exc;
  assign fp_unavail_exc = i_valid && !i_unimplemented && i_is_float &&
    !machine_state_reg[MS_FAVAIL];
  assign decr_exc = decr_pending && machine_state_reg[MS_IRQEN];
  assign syscall_exc = i_valid && !i_unimplemented && i_system_call_op;
  assign syscall_go = (sync_state == ST_SYNC) && i_inflight_empty;

  // fixed priority: sync entries first, then instruction faults, then the decrementer
  always_comb begin
    take = EV_NONE;
    if (syscall_go) begin
      take = EV_SYSCALL;
    end else if (sync_state == ST_RUN && !o_sw_emulation) begin
      if (i_valid && i_align_fault) begin
        take = EV_ALIGN;
      end else if (program_exc) begin
        take = EV_PROGRAM;
      end else if (fp_unavail_exc) begin
        take = EV_FP_UNAVAIL;
      end else if (decr_exc) begin
        take = EV_DECR;
      end
    end
  end

  assign vec_base = machine_state_reg[MS_VBASE] ? VEC_BASE_HIGH :
    VEC_BASE_LOW;

  always_comb begin
    entry_state = 32'h0000_0000;
    entry_state[MS_VBASE] = machine_state_reg[MS_VBASE];
    entry_state[MS_MCE] = machine_state_reg[MS_MCE];
    entry_state[MS_BO] = machine_state_reg[MS_XBO];
  end

  // context sync around the system call
  always_comb begin
    next_sync_state = sync_state;
    case (sync_state)
      ST_RUN: begin
        if (syscall_exc && !i_align_fault && !program_exc &&
            !fp_unavail_exc) begin
          next_sync_state = ST_SYNC;
        end
      end
      ST_SYNC: begin
        if (i_inflight_empty) begin
          next_sync_state = ST_RUN;
        end
      end
      default: next_sync_state = ST_RUN;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      sync_state <= ST_RUN;
    end else begin
      sync_state <= next_sync_state;
    end
  end

  // system call return address held while syncing
  logic [31:0] sc_next_addr;
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      sc_next_addr <= 32'h0000_0000;
    end else if (sync_state == ST_RUN && next_sync_state == ST_SYNC) begin
      sc_next_addr <= i_next_addr;
    end
  end

  always_comb begin
    o_halt_dispatch = (sync_state == ST_SYNC);
  end

  // redirect and new context presented one cycle after entry
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_redirect <= 1'b0;
      o_redirect_addr <= 32'h0000_0000;
    end else begin
      o_redirect <= (take != EV_NONE);
      case (take)
        EV_ALIGN: o_redirect_addr <= vec_base | 32'h0000_0600;
        EV_PROGRAM: o_redirect_addr <= vec_base | VEC_PROGRAM;
        EV_FP_UNAVAIL: o_redirect_addr <= vec_base | VEC_FP_UNAVAIL;
        EV_DECR: o_redirect_addr <= vec_base | VEC_DECREMENTER;
        EV_SYSCALL: o_redirect_addr <= vec_base | VEC_SYSCALL;
        default: o_redirect_addr <= o_redirect_addr;
      endcase
    end
  end

  assign sw_state_write = apb_wr && i_paddr == ADDR_MSTATE;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      machine_state_reg <= 32'h0000_0000;
    end else if (take != EV_NONE) begin
      machine_state_reg <= entry_state;
    end else if (i_valid && i_is_state_write && !priv_exc) begin
      machine_state_reg <= i_state_wdata;
    end else if (i_valid && i_is_return && !priv_exc) begin
      machine_state_reg <= i_return_state;
    end else if (sw_state_write) begin
      machine_state_reg <= i_pwdata;
    end
  end
  assign o_machine_state = machine_state_reg;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      float_status_control <= 32'h0000_0000;
    end else if (i_valid && i_is_fstatus_write && take == EV_NONE) begin
      float_status_control <= i_fstatus_wdata;
    end else if (apb_wr && i_paddr == ADDR_FSTATUS) begin
      float_status_control <= i_pwdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      save_restore_address <= 32'h0000_0000;
    end else begin
      case (take)
        EV_ALIGN: save_restore_address <= i_inst_addr;
        EV_PROGRAM: save_restore_address <= i_later_addr ? i_next_addr :
          i_inst_addr;
        EV_FP_UNAVAIL: save_restore_address <= i_inst_addr;
        EV_DECR: save_restore_address <= i_valid ? i_inst_addr :
          i_next_addr;
        EV_SYSCALL: save_restore_address <= sc_next_addr;
        default: begin
          if (apb_wr && i_paddr == ADDR_SR_ADDR) begin
            save_restore_address <= i_pwdata;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      save_restore_status <= 32'h0000_0000;
    end else if (take == EV_PROGRAM) begin
      save_restore_status <= {16'h0000, machine_state_reg[15:0]};
      save_restore_status[SS_FPEN] <= fp_enabled_exc;
      save_restore_status[SS_PRIV] <= priv_exc;
      save_restore_status[SS_TRAP] <= trap_exc;
      save_restore_status[SS_LATER] <= i_later_addr;
    end else if (take != EV_NONE) begin
      // high half cleared, low half copied from machine state (for system call too)
      save_restore_status <= {16'h0000, machine_state_reg[15:0]};
      save_restore_status[31:16] <= 16'h0000;
    end else if (apb_wr && i_paddr == ADDR_SR_STAT) begin
      save_restore_status <= i_pwdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      alignment_syndrome <= 32'h0000_0000;
    end else if (take == EV_ALIGN) begin
      alignment_syndrome <= 32'h0000_0000;
      case (i_ls_class)
        LS_STORE_WORD: alignment_syndrome[SYN_LSB +: 7] <= CLS_STORE_WORD;
        LS_LOAD_WORD_IDX:
          alignment_syndrome[SYN_LSB +: 7] <= CLS_LOAD_WORD_IDX;
        default: alignment_syndrome[SYN_LSB +: 7] <= CLS_LOAD_WORD;
      endcase
    end else if (apb_wr && i_paddr == ADDR_SYNDROME) begin
      alignment_syndrome <= i_pwdata;
    end
  end

  // decrementer
  always_comb begin
    next_decr = decr - DECR_WIDTH'(1);
    if (apb_wr && i_paddr == ADDR_DECR) begin
      next_decr = i_pwdata[DECR_WIDTH-1:0];
    end
  end
  assign decr_rise = !decr[DECR_WIDTH-1] && next_decr[DECR_WIDTH-1];

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      decr <= DECR_RESET[DECR_WIDTH-1:0];
    end else begin
      decr <= next_decr;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      decr_pending <= 1'b0;
    end else if (decr_rise) begin
      decr_pending <= 1'b1;
    end else if (take == EV_DECR) begin
      decr_pending <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      event_count <= 32'h0000_0000;
    end else if (take != EV_NONE) begin
      event_count <= event_count + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      case (i_paddr)
        ADDR_MSTATE: o_prdata <= machine_state_reg;
        ADDR_SR_ADDR: o_prdata <= save_restore_address;
        ADDR_SR_STAT: o_prdata <= save_restore_status;
        ADDR_SYNDROME: o_prdata <= alignment_syndrome;
        ADDR_DECR: o_prdata <= 32'(decr);
        ADDR_FSTATUS: o_prdata <= float_status_control;
        ADDR_EVENT: o_prdata <= {event_count[27:0], 1'b0,
          decr_pending, o_halt_dispatch, 1'b0};
        default: o_prdata <= APB_DEAD;
      endcase
    end
  end
endmodule

// *** exc_entry_checker.sv ***
// assertion checker bound to the exception-entry unit
`timescale 1ns/100ps
module exc_entry_checker
  import exc_entry_pkg::*;
#(
  parameter int DECR_WIDTH = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_valid,
  input wire logic i_align_fault,
  input wire logic i_is_state_read,
  input wire logic i_trap_met,
  input wire logic i_is_float,
  input wire logic i_float_arith_enabled,
  input wire logic i_unimplemented,
  input wire logic i_system_call_op,
  input wire logic i_inflight_empty,
  input wire logic o_redirect,
  input wire logic [31:0] o_redirect_addr,
  input wire logic o_halt_dispatch,
  input wire logic o_fp_assist,
  input wire logic o_sw_emulation,
  input wire logic [31:0] o_machine_state
);
  localparam logic [31:0] KEEP = (32'h1 << MS_VBASE) | (32'h1 << MS_MCE) |
    (32'h1 << MS_BO);
  logic oth;
  logic [11:0] off;
  assign oth = i_align_fault | i_unimplemented | i_system_call_op;
  assign off = o_redirect_addr[11:0];
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  property p_emul; i_valid && i_unimplemented |-> o_sw_emulation; endproperty
  a_emul: assert property (p_emul) else $error("no emulation");
  property p_assist; o_fp_assist |-> i_valid && i_float_arith_enabled; endproperty
  a_assist: assert property (p_assist) else $error("bad assist");
  property p_msr; o_redirect |-> (o_machine_state & ~KEEP) == 32'h0; endproperty
  a_msr: assert property (p_msr) else $error("entry state");
  property p_fpu;
    i_valid && i_is_float && !o_machine_state[MS_FAVAIL] && !oth && !i_trap_met
      && !i_is_state_read && !i_float_arith_enabled
      |=> o_redirect && off == 12'h800;
  endproperty
  a_fpu: assert property (p_fpu) else $error("fp unavailable");
  property p_priv;
    i_valid && i_is_state_read && o_machine_state[MS_USER] && !oth
      |=> o_redirect && off == 12'h700;
  endproperty
  a_priv: assert property (p_priv) else $error("privileged");
  property p_trap; i_valid && i_trap_met && !oth |=> o_redirect && off == 12'h700;
  endproperty
  a_trap: assert property (p_trap) else $error("trap");
  property p_sync;
    i_valid && i_system_call_op && !i_unimplemented && !i_inflight_empty
      |=> o_halt_dispatch;
  endproperty
  a_sync: assert property (p_sync) else $error("no halt");
  property p_hold; o_halt_dispatch && !i_inflight_empty |=> !o_redirect;
  endproperty
  a_hold: assert property (p_hold) else $error("early entry");
  property p_sys;
    o_halt_dispatch && i_inflight_empty |-> ##[1:2] o_redirect && off == 12'hC00;
  endproperty
  a_sys: assert property (p_sys) else $error("system call");
  c_decr: cover property (o_redirect && off == 12'h900);
  c_halt: cover property (o_halt_dispatch);
  c_assist: cover property (o_fp_assist);
endmodule
bind exception_entry_unit exc_entry_checker #(.DECR_WIDTH(DECR_WIDTH)) chk (
  .i_clk_sys, .i_reset, .i_valid, .i_align_fault, .i_is_state_read,
  .i_trap_met, .i_is_float, .i_float_arith_enabled, .i_unimplemented,
  .i_system_call_op, .i_inflight_empty, .o_redirect, .o_redirect_addr,
  .o_halt_dispatch, .o_fp_assist, .o_sw_emulation, .o_machine_state
);

// *** pipeline_model.sv ***
// pipeline and dispatch model feeding the decode side
`timescale 1ns/100ps
module pipeline_model (
  input wire logic i_clk_sys,
  input wire logic i_halt,
  output logic o_valid = 1'h0,
  output logic [14:0] o_flags = 15'h0,
  output logic [1:0] o_cls = 2'h0,
  output logic [31:0] o_data = 32'h0,
  output logic [31:0] o_addr = 32'h0,
  output logic o_empty
);
  logic [31:0] pc = 32'h0000_2000;
  logic [31:0] last = 32'h0;
  int age = 9;
  // the decoded instruction counts as in flight too
  assign o_empty = age > 2 && !o_valid;
  always @(posedge i_clk_sys)
    age <= o_valid ? 0 : age + 1;
  task automatic issue(input logic [14:0] f, input logic [1:0] c,
                       input logic [31:0] d);
    int n;
    n = 0;
    while (i_halt === 1'h1 && n < 50) begin
      @(posedge i_clk_sys);
      n++;
    end
    last = pc;
    o_valid <= 1'h1;
    o_flags <= f;
    o_cls <= c;
    o_data <= d;
    o_addr <= pc;
    pc = pc + 32'h10;
    @(posedge i_clk_sys);
    // idle qualifiers carry garbage; idle address makes next address = pc
    o_valid <= 1'h0;
    o_flags <= ~f;
    o_cls <= ~c;
    o_data <= ~d;
    o_addr <= pc - 32'h4;
  endtask
endmodule

// *** exception_entry_unit_test.sv ***
// self-checking testbench for the exception-entry unit
`timescale 1ns/100ps
module exception_entry_unit_test;
  import exc_entry_pkg::*;
  localparam logic [14:0] AL = 15'h0001, FW = 15'h0010, TR = 15'h0200;
  localparam logic [14:0] FL = 15'h0400, FA = 15'h0800, UN = 15'h1000;
  localparam logic [14:0] SC = 15'h2000, LA = 15'h4000;
  localparam logic [31:0] VEC_AL = 32'h0000_0600;
  logic [14:0] priv [5] = '{15'h0002, 15'h0004, 15'h0008, 15'h0160, 15'h00E0};
  logic [6:0] cls_exp [4] = '{7'h00, 7'h02, 7'h60, 7'h00};
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, raddr, ms, data, iaddr, vec, r;
  logic pready, pslverr, redir, halt, assist, emul, valid, empty;
  logic [14:0] fl;
  logic [1:0] cls;
  int errors = 0, n_checks = 0, nred = 0, nast = 0, nemu = 0;
  exception_entry_unit #(.DECR_WIDTH(32)) dut (
    .i_clk_sys(clk), .i_reset(rst), .i_valid(valid), .i_inst_addr(iaddr),
    .i_next_addr(iaddr + 32'h4), .i_later_addr(fl[14]),
    .i_align_fault(fl[0]), .i_ls_class(cls), .i_is_state_read(fl[1]),
    .i_is_state_write(fl[2]), .i_is_return(fl[3]),
    .i_is_fstatus_write(fl[4]), .i_is_spr_move(fl[5]),
    .i_supervisor_reg_flag(fl[6]), .i_spr_valid_internal(fl[7]),
    .i_spr_external(fl[8]), .i_trap_met(fl[9]), .i_is_float(fl[10]),
    .i_float_arith_enabled(fl[11]), .i_unimplemented(fl[12]),
    .i_system_call_op(fl[13]), .i_inflight_empty(empty),
    .i_fstatus_wdata(data), .i_state_wdata(data), .i_return_state(data),
    .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_redirect(redir), .o_redirect_addr(raddr),
    .o_halt_dispatch(halt), .o_fp_assist(assist), .o_sw_emulation(emul),
    .o_machine_state(ms));
  pipeline_model pm (.i_clk_sys(clk), .i_halt(halt), .o_valid(valid),
    .o_flags(fl), .o_cls(cls), .o_data(data), .o_addr(iaddr), .o_empty(empty));
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    if (redir === 1'h1) begin
      nred <= nred + 1;
      vec <= raddr;
    end
    if (assist === 1'h1) nast <= nast + 1;
    if (emul === 1'h1) nemu <= nemu + 1;
  end
  task automatic check(input string what, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    if (errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      errors++;
      stop_test;
    end
    r = prdata;
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask
  // issue one instruction, then count redirects and check the vector
  task automatic go(input logic [14:0] f, input logic [1:0] c,
                    input logic [31:0] d, input int k, input logic [31:0] v);
    int n0;
    n0 = nred;
    pm.issue(f, c, d);
    repeat (8) @(posedge clk);
    check("redirects", 32'(nred - n0), 32'(k));
    if (k != 0) check("vector", vec, v);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    stop_test;
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    apb(1'h0, ADDR_MSTATE, 32'h0);
    check("state reset", r, 32'h0);
    apb(1'h0, 8'h1C, 32'h0);
    check("unmapped", r, 32'h0);
    for (int i = 0; i < 4; i++) begin
      go(AL, 2'(i), 32'h0, 1, VEC_AL);
      apb(1'h0, ADDR_SYNDROME, 32'h0);
      check("class", 32'(r[16:10]), 32'(cls_exp[i]));
    end
    for (int i = 0; i < 5; i++) begin
      apb(1'h1, ADDR_MSTATE, 32'h0001_5048);
      go(priv[i], 2'h0, 32'h0, 1, 32'hFFF0_0700);
      apb(1'h0, ADDR_SR_STAT, 32'h0);
      check("priv status", r, 32'h0004_5048);
      check("entry state", ms, 32'h0000_1041);
    end
    apb(1'h1, ADDR_MSTATE, 32'h0);
    go(TR | LA, 2'h0, 32'h0, 1, 32'h0000_0700);
    apb(1'h0, ADDR_SR_STAT, 32'h0);
    check("trap status", r, 32'h0003_0000);
    apb(1'h1, ADDR_FSTATUS, 32'h4000_0000);
    for (int j = 0; j < 2; j++) begin
      apb(1'h1, ADDR_MSTATE, j ? 32'h100 : 32'h800);
      go(FW, 2'h0, 32'h4000_0000, 1, 32'h0000_0700);
      apb(1'h0, ADDR_SR_STAT, 32'h0);
      check("fp status", r, 32'h0010_0000 | (j ? 32'h100 : 32'h800));
    end
    apb(1'h1, ADDR_MSTATE, 32'h0000_2800);
    go(FA | FL, 2'h0, 32'h0, 0, 32'h0);
    check("assist", 32'(nast), 32'h1);
    go(UN | TR, 2'h0, 32'h0, 0, 32'h0);
    check("emulation", 32'(nemu), 32'h1);
    apb(1'h1, ADDR_MSTATE, 32'h0);
    go(FL, 2'h0, 32'h0, 1, 32'h0000_0800);
    apb(1'h0, ADDR_SR_ADDR, 32'h0);
    check("fp save addr", r, pm.last);
    go(AL | TR, 2'h1, 32'h0, 1, VEC_AL);
    apb(1'h0, ADDR_SR_STAT, 32'h0);
    check("align first", 32'(r[SS_TRAP]), 32'h0);
    apb(1'h1, ADDR_MSTATE, 32'h0001_0040);
    go(SC, 2'h0, 32'h0, 1, 32'hFFF0_0C00);
    apb(1'h0, ADDR_SR_ADDR, 32'h0);
    check("sc save addr", r, pm.last + 32'h4);
    apb(1'h0, ADDR_SR_STAT, 32'h0);
    check("sc status", r, 32'h0000_0040);
    check("sc state", ms, 32'h0000_0041);
    apb(1'h1, ADDR_MSTATE, 32'h0);
    apb(1'h1, ADDR_DECR, 32'h0000_1000);
    apb(1'h0, ADDR_DECR, 32'h0);
    check("count", 32'(r <= 32'h1000 && r > 32'hFF0), 32'h1);
    apb(1'h1, ADDR_DECR, 32'h0);
    go(15'h0, 2'h0, 32'h0, 0, 32'h0);
    apb(1'h1, ADDR_DECR, 32'h0);
    apb(1'h1, ADDR_MSTATE, 32'h0000_8000);
    go(15'h0, 2'h0, 32'h0, 1, 32'h0000_0900);
    apb(1'h0, ADDR_SR_ADDR, 32'h0);
    check("decr save addr", r, pm.last);
    apb(1'h0, ADDR_SR_STAT, 32'h0);
    check("decr status", r, 32'h0000_8000);
    apb(1'h1, ADDR_MSTATE, 32'h0000_8000);
    go(15'h0, 2'h0, 32'h0, 0, 32'h0);
    stop_test;
  end
endmodule
